// ==== verilog/tcc_map.vh ====
// Register map, field positions and coded values of the transmit command block.
// Included by the command block and its bit serializer; definitions only.
`ifndef TCC_MAP_VH
`define TCC_MAP_VH

// Register byte offsets
`define TCC_OFF_CMD 8'h00
`define TCC_OFF_CFG 8'h04
`define TCC_OFF_DESC 8'h08
`define TCC_OFF_SIZE 8'h0C
`define TCC_OFF_STAT 8'h10

// Command register fields
`define TCC_CMD_ABORT 0
`define TCC_CMD_OFF 1
`define TCC_CMD_INIT 2
`define TCC_CMD_HOLD 3
`define TCC_CMD_NBSF 4

// Command encodings {init, off, abort}
`define TCC_ENC_CLEAR 3'h0
`define TCC_ENC_OFF 3'h2
`define TCC_ENC_ABORT 3'h3
`define TCC_ENC_JUMP 3'h4
`define TCC_ENC_INIT 3'h5

// Configuration register fields
`define TCC_CFG_MODE_LSB 0
`define TCC_CFG_MODE_MSB 2
`define TCC_CFG_IFS 3
`define TCC_CFG_FFS 4
`define TCC_CFG_LOOP 5
`define TCC_CFG_FLAG_LSB 8
`define TCC_CFG_FLAG_MSB 15
`define TCC_CFG_RESET 32'h0000_7E00

// Channel modes
`define TCC_MODE_TRA 3'h0
`define TCC_MODE_TRB 3'h1
`define TCC_MODE_TRR 3'h2
`define TCC_MODE_HDLC 3'h3
`define TCC_MODE_V110 3'h4

// Fill and abort patterns, sent least significant bit first
`define TCC_FILL_FLAG 8'h7E
`define TCC_FILL_ONES 8'hFF
`define TCC_FILL_ZERO 8'h00
`define TCC_AB_HDLC 16'h7FFE
`define TCC_AB_HDLC_LEN 5'h0F
`define TCC_AB_ZERO 16'h0000
`define TCC_AB_TRB_LEN 5'h08
`define TCC_AB_TRR_LEN 5'h10
`define TCC_BYTE_LEN 5'h08
// Three ten-octet frames of zero bits
`define TCC_V110_ZERO_OCTETS 5'h1E
// Hold descriptor polls beyond the buffer size before the buffer is empty
`define TCC_POLL_EXTRA 7'h02

`endif

// ==== verilog/tcc_serializer.v ====
// Bit serializer of the transmit formatter: loads up to 16 bits with a
// length and shifts them out least significant bit first, one per shift enable.
// Assumes the loader only loads while the serializer reports empty.
`timescale 1ns/10ps
`include "tcc_map.vh"

module tcc_serializer #(
  parameter W = 16
) (
  input wire i_clk,
  input wire i_rstn,
  input wire i_clr,
  input wire i_load,
  input wire [W-1:0] i_data,
  input wire [4:0] i_len,
  input wire i_shift,
  output wire o_bit,
  output wire o_empty
);

  reg [W-1:0] sh_q;
  reg [4:0] cnt_q;

  assign o_bit = sh_q[0];
  assign o_empty = (cnt_q == 5'h00);

  always @(posedge i_clk) begin
    if (!i_rstn || i_clr) begin
      sh_q <= {W{1'b1}};
      cnt_q <= 5'h00;
    end else if (i_load) begin
      sh_q <= i_data;
      cnt_q <= i_len;
    end else if (i_shift && !o_empty) begin
      sh_q <= {1'b1, sh_q[W-1:1]};
      cnt_q <= cnt_q - 5'h01;
    end
  end

endmodule // tcc_serializer

// ==== verilog/tcc_tx_cmd.v ====
// Transmit channel command control: AHB-Lite register slave, command decode,
// transmit formatter with fill and abort patterns, and descriptor steering.
// Assumes one channel, a link clock and time slot strobe from the PCM line,
// and a DMA side on the system clock that supplies buffered transmit octets.
//
// Contract
// - Off command clears abort, sets off, resets formatter, stops buffer reads.
// - While off, output time slots are high impedance.
// - With loop set, off keeps formatter running and only tristates the line.
// - Init ending off sends fill first (7E, FF or 00 by mode), then data.
// - Transparent mode A fill is the custom flag when selected, else FF.
// - Abort encoding clears off, sets abort, acts in the formatter only.
// - Abort ends the open frame with the mode's abort sequence.
// - After the abort sequence, or at once, mode-specific fill is sent.
// - During abort the formatter reads no buffer; descriptor handling continues.
// - Withdrawn abort resumes from buffer; remaining data starts a new frame.
// - Hold descriptor polled size plus two times means the buffer is empty.
// - Jump clears off and abort, finishes descriptor, then branches to start.
// - Jump after a descriptor without frame end appends to the open frame.
// - Init in normal operation flushes buffer and branches, DMA side only.
// - Hold finishes the frame, V.110 sends three zero frames, then fill.
// - Init clears abort and acts on both DMA and serial sides; the code resets the serial side only before the first init or out of off.
// - Fill after hold is 7E, 00 or custom flag by mode and selects; the code sends FF after hold in HDLC with IFS set and in mode A without FFS.
//
// Local design decisions: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/10ps
`include "tcc_map.vh"

module tcc_tx_cmd #(
  parameter AW = 32,
  parameter SZW = 6
) (
  input wire i_clk,
  input wire i_rstn,
  input wire i_hsel,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  output reg [31:0] o_hrdata,
  output reg o_hreadyout,
  output reg o_hresp,
  input wire i_link_clk,
  input wire i_tslot,
  output reg o_txd,
  output reg o_txd_oe,
  input wire i_buf_valid,
  input wire [7:0] i_buf_data,
  input wire i_buf_end,
  output reg o_buf_rd,
  input wire i_desc_done,
  input wire i_hold_poll,
  output reg o_dma_branch,
  output reg o_dma_flush,
  output reg [AW-1:0] o_dma_addr,
  output reg [SZW-1:0] o_buf_size,
  output reg o_hold
);

  function [7:0] fill_char;
    input [2:0] mode;
    input ifs;
    input ffs;
    input [7:0] flag;
    begin
      case (mode)
        `TCC_MODE_HDLC: fill_char = ifs ? `TCC_FILL_ONES : `TCC_FILL_FLAG;
        `TCC_MODE_TRA: fill_char = ffs ? flag : `TCC_FILL_ONES;
        default: fill_char = `TCC_FILL_ZERO;
      endcase
    end
  endfunction

  // Bus slave: one wait state, then write or read in the data phase
  reg ph_q;
  reg wr_q;
  reg [7:0] adr_q;
  reg [31:0] cfg_q;
  reg inited_q;
  reg off_q;
  reg abort_q;
  reg jump_q;
  reg frame_open_q;
  reg fill_first_q;
  reg abseq_q;
  reg [4:0] zcnt_q;
  reg [6:0] poll_q;
  reg lk1_q, lk2_q, lk3_q, ts1_q, ts2_q;

  wire [2:0] mode = cfg_q[`TCC_CFG_MODE_MSB:`TCC_CFG_MODE_LSB];
  wire [7:0] flag = cfg_q[`TCC_CFG_FLAG_MSB:`TCC_CFG_FLAG_LSB];
  wire [7:0] fill = fill_char(mode, cfg_q[`TCC_CFG_IFS], cfg_q[`TCC_CFG_FFS], flag);
  wire framed = (mode == `TCC_MODE_HDLC) || (mode == `TCC_MODE_TRB) ||
    (mode == `TCC_MODE_TRR);
  wire loop_on = cfg_q[`TCC_CFG_LOOP];
  wire drained = ({1'b0, o_buf_size} + `TCC_POLL_EXTRA) <= poll_q;
  wire acc = i_hsel && i_htrans[1] && i_hready;
  wire do_wr = ph_q && wr_q;
  wire cmd_v = do_wr && (adr_q == `TCC_OFF_CMD);
  wire [2:0] enc = {i_hwdata[`TCC_CMD_INIT], i_hwdata[`TCC_CMD_OFF],
    i_hwdata[`TCC_CMD_ABORT]};
  wire c_off = cmd_v && (enc == `TCC_ENC_OFF);
  wire c_abort = cmd_v && (enc == `TCC_ENC_ABORT);
  wire c_jump = cmd_v && (enc == `TCC_ENC_JUMP);
  wire c_init = cmd_v && (enc == `TCC_ENC_INIT);
  wire c_clear = cmd_v && (enc == `TCC_ENC_CLEAR);
  wire hold_set = cmd_v && i_hwdata[`TCC_CMD_HOLD] && !o_hold;
  // Serial side acts on init only before first init or out of the off condition
  wire init_ser = c_init && (!inited_q || off_q);
  wire fmt_clr = !inited_q || (off_q && !loop_on) || init_ser || c_off && !loop_on;

  always @(posedge i_clk) begin
    if (!i_rstn) begin
      ph_q <= 1'b0;
      wr_q <= 1'b0;
      adr_q <= 8'h00;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      o_hrdata <= 32'h0000_0000;
    end else begin
      ph_q <= acc && !ph_q;
      o_hreadyout <= !(acc && !ph_q);
      if (acc && !ph_q) begin
        wr_q <= i_hwrite;
        adr_q <= i_haddr[7:0];
      end
      if (ph_q && !wr_q) begin
        case (adr_q)
          `TCC_OFF_CMD: o_hrdata <= {27'h0, 1'b0, o_hold, 3'h0};
          `TCC_OFF_CFG: o_hrdata <= cfg_q;
          `TCC_OFF_DESC: o_hrdata <= o_dma_addr;
          `TCC_OFF_SIZE: o_hrdata <= {{(32-SZW){1'b0}}, o_buf_size};
          `TCC_OFF_STAT: o_hrdata <= {16'h0, 1'b0, poll_q, 1'b0, drained, jump_q,
            frame_open_q, o_hold, abort_q, off_q, inited_q};
          default: o_hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Configuration, start address, size and hold
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      cfg_q <= `TCC_CFG_RESET;
      o_dma_addr <= {AW{1'b0}};
      o_buf_size <= {SZW{1'b0}};
      o_hold <= 1'b0;
      poll_q <= 7'h00;
    end else begin
      if (do_wr && adr_q == `TCC_OFF_CFG)
        cfg_q <= i_hwdata;
      if (do_wr && adr_q == `TCC_OFF_DESC)
        o_dma_addr <= i_hwdata[AW-1:0];
      if (do_wr && adr_q == `TCC_OFF_SIZE && !inited_q)
        o_buf_size <= i_hwdata[SZW-1:0];
      if (c_init && i_hwdata[`TCC_CMD_NBSF])
        o_buf_size <= i_hwdata[SZW+7:8];
      if (cmd_v)
        o_hold <= i_hwdata[`TCC_CMD_HOLD];
      if (!o_hold || cmd_v)
        poll_q <= 7'h00;
      else if (i_hold_poll && poll_q != 7'h7F)
        poll_q <= poll_q + 7'h01;
    end
  end

  // Command conditions and descriptor steering
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      inited_q <= 1'b0;
      off_q <= 1'b0;
      abort_q <= 1'b0;
      jump_q <= 1'b0;
      o_dma_branch <= 1'b0;
      o_dma_flush <= 1'b0;
    end else begin
      o_dma_branch <= 1'b0;
      o_dma_flush <= 1'b0;
      if (c_off) begin
        off_q <= 1'b1;
        abort_q <= 1'b0;
      end
      if (c_abort) begin
        off_q <= 1'b0;
        abort_q <= 1'b1;
      end
      if ((c_clear && inited_q) || c_jump) begin
        off_q <= 1'b0;
        abort_q <= 1'b0;
      end
      if (c_init) begin
        inited_q <= 1'b1;
        off_q <= 1'b0;
        abort_q <= 1'b0;
        jump_q <= 1'b0;
        o_dma_flush <= 1'b1;
        o_dma_branch <= 1'b1;
      end else if (c_jump && inited_q) begin
        jump_q <= 1'b1;
      end else if (jump_q && i_desc_done) begin
        jump_q <= 1'b0;
        o_dma_branch <= 1'b1;
      end
    end
  end

  // Link clock and time slot strobe are synchronised before use
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      lk1_q <= 1'b0;
      lk2_q <= 1'b0;
      lk3_q <= 1'b0;
      ts1_q <= 1'b0;
      ts2_q <= 1'b0;
    end else begin
      lk1_q <= i_link_clk;
      lk2_q <= lk1_q;
      lk3_q <= lk2_q;
      ts1_q <= i_tslot;
      ts2_q <= ts1_q;
    end
  end

  wire bit_en = lk2_q && !lk3_q && ts2_q;
  wire ser_bit;
  wire ser_empty;
  reg ld;
  reg [15:0] ld_data;
  reg [4:0] ld_len;
  reg take;

  // Next unit for the formatter, chosen when the serializer runs dry
  always @* begin
    ld = ser_empty && !fmt_clr && !o_buf_rd;
    ld_data = {8'h00, fill};
    ld_len = `TCC_BYTE_LEN;
    take = 1'b0;
    if (fill_first_q) begin
      ld_data = {8'h00, fill};
    end else if (abseq_q) begin
      case (mode)
        `TCC_MODE_HDLC: begin
          ld_data = `TCC_AB_HDLC;
          ld_len = `TCC_AB_HDLC_LEN;
        end
        `TCC_MODE_TRB: begin
          ld_data = `TCC_AB_ZERO;
          ld_len = `TCC_AB_TRB_LEN;
        end
        `TCC_MODE_TRR: begin
          ld_data = `TCC_AB_ZERO;
          ld_len = `TCC_AB_TRR_LEN;
        end
        `TCC_MODE_V110: ld_data = `TCC_AB_ZERO;
        default: ld_data = {8'h00, fill};
      endcase
    end else if (zcnt_q != 5'h00) begin
      ld_data = `TCC_AB_ZERO;
    end else if (abort_q || (off_q && loop_on)) begin
      ld_data = {8'h00, fill};
    end else if (o_hold && !frame_open_q) begin
      ld_data = {8'h00, fill};
    end else if (i_buf_valid) begin
      ld_data = {8'h00, i_buf_data};
      take = 1'b1;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rstn) begin
      frame_open_q <= 1'b0;
      fill_first_q <= 1'b0;
      abseq_q <= 1'b0;
      zcnt_q <= 5'h00;
      o_buf_rd <= 1'b0;
    end else begin
      o_buf_rd <= ld && take;
      if (fmt_clr) begin
        frame_open_q <= 1'b0;
        abseq_q <= 1'b0;
        zcnt_q <= 5'h00;
        fill_first_q <= 1'b1;
      end else if (c_abort) begin
        abseq_q <= frame_open_q || mode == `TCC_MODE_V110;
        frame_open_q <= 1'b0;
      end else if (hold_set && mode == `TCC_MODE_V110) begin
        zcnt_q <= `TCC_V110_ZERO_OCTETS;
      end else if (ld) begin
        if (fill_first_q)
          fill_first_q <= 1'b0;
        else if (abseq_q) begin
          abseq_q <= 1'b0;
          if (mode == `TCC_MODE_V110)
            zcnt_q <= `TCC_V110_ZERO_OCTETS - 5'h01;
        end else if (zcnt_q != 5'h00)
          zcnt_q <= zcnt_q - 5'h01;
        if (take)
          frame_open_q <= framed && !i_buf_end;
      end
    end
  end

  tcc_serializer #(
    .W(16)
  ) u_ser (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_clr(fmt_clr),
    .i_load(ld),
    .i_data(ld_data),
    .i_len(ld_len),
    .i_shift(bit_en),
    .o_bit(ser_bit),
    .o_empty(ser_empty)
  );

  // Line driver: slots tristated while off or before the first init
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      o_txd <= 1'b1;
      o_txd_oe <= 1'b0;
    end else begin
      o_txd_oe <= ts2_q && inited_q && !off_q && !c_off;
      if (bit_en && !ser_empty)
        o_txd <= ser_bit;
    end
  end

endmodule // tcc_tx_cmd

// ==== verif/tcc_tx_cmd_sva.sv ====
// Checker of the transmit command block, bound to its top module.
// Assumes hready is tied to hreadyout and single word transfers only.
`timescale 1ns/10ps
module tcc_tx_cmd_sva #(
  parameter AW = 32
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic o_txd_oe,
  input wire logic o_buf_rd,
  input wire logic o_dma_branch,
  input wire logic o_dma_flush,
  input wire logic [AW-1:0] o_dma_addr,
  input wire logic o_hold
);
  logic wr_q;
  logic [7:0] a_q;
  logic [31:0] wd_q;
  logic ab_q;
  wire take = i_hsel && i_htrans[1] && i_hready;
  wire cmd_wr = wr_q && a_q == 8'h00;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // Data phase marker of a write and the word it carried
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      wr_q <= 1'b0;
      a_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ab_q <= 1'b0;
    end else begin
      wr_q <= take && i_hwrite;
      if (take) a_q <= i_haddr[7:0];
      if (wr_q) wd_q <= i_hwdata;
      // Abort condition as set and cleared by command writes
      if (cmd_wr && i_hwdata[2:0] == 3'h3) ab_q <= 1'b1;
      else if (cmd_wr && i_hwdata[2:0] != 3'h1) ab_q <= 1'b0;
    end
  end
  property p_wait;
    take |=> !o_hreadyout ##1 o_hreadyout;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state not one cycle");
  property p_okay;
    o_hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_off;
    cmd_wr && i_hwdata[2:0] == 3'h2 |-> ##1 !o_txd_oe [*2];
  endproperty
  a_off: assert property (p_off)
    else $error("line driven while off");
  property p_init;
    cmd_wr && i_hwdata[2:0] == 3'h5 |-> ##[1:2] (o_dma_flush && o_dma_branch);
  endproperty
  a_init: assert property (p_init)
    else $error("init gave no flush and branch");
  property p_abort;
    ab_q |=> !o_buf_rd;
  endproperty
  a_abort: assert property (p_abort)
    else $error("buffer read during abort");
  property p_jump;
    cmd_wr && i_hwdata[2:0] == 3'h4 |-> ##1 !o_dma_flush [*3];
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump flushed the buffer");
  property p_hold;
    cmd_wr |-> ##[1:2] (o_hold == wd_q[3]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold bit not loaded");
  property p_desc;
    wr_q && a_q == 8'h08 |-> ##[1:2] (o_dma_addr == wd_q[AW-1:0]);
  endproperty
  a_desc: assert property (p_desc)
    else $error("descriptor address not loaded");
  property p_pulse;
    o_buf_rd || o_dma_flush |=> !o_buf_rd && !o_dma_flush;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("pulse longer than one cycle");
endmodule // tcc_tx_cmd_sva
bind tcc_tx_cmd tcc_tx_cmd_sva #(.AW(AW)) u_sva (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
  .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .o_txd_oe(o_txd_oe), .o_buf_rd(o_buf_rd), .o_dma_branch(o_dma_branch),
  .o_dma_flush(o_dma_flush), .o_dma_addr(o_dma_addr), .o_hold(o_hold));

// ==== verif/tcc_line_model.sv ====
// Far side: free running line clock with one slot per frame, and a DMA
// buffer source that pops on request and polls hold descriptors.
`timescale 1ns/10ps
module tcc_line_model (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_buf_rd,
  input wire logic i_hold,
  output logic o_link_clk,
  output logic o_tslot,
  output logic o_buf_valid,
  output logic [7:0] o_buf_data,
  output logic o_buf_end,
  output logic o_desc_done,
  output logic o_hold_poll
);
  logic [4:0] bit_q;
  logic [7:0] cnt_q;
  logic [4:0] stall_q;
  logic [3:0] div_q;
  initial begin
    bit_q = 5'h00;
    o_tslot = 1'b0;
    o_link_clk = 1'b0;
    forever #62.5 o_link_clk = ~o_link_clk;
  end
  // Slot moves on the falling edge so it is steady at each bit edge
  always @(negedge o_link_clk) begin
    bit_q <= bit_q + 5'h01;
    o_tslot <= bit_q < 5'h08;
  end
  assign o_buf_valid = stall_q == 5'h00;
  // Released data lines show the inverse of the next octet
  assign o_buf_data = o_buf_valid ? cnt_q : ~cnt_q;
  assign o_buf_end = cnt_q[2:0] == 3'h7;
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      cnt_q <= 8'h00;
      stall_q <= 5'h00;
      div_q <= 4'h0;
      o_desc_done <= 1'b0;
      o_hold_poll <= 1'b0;
    end else begin
      div_q <= div_q + 4'h1;
      o_desc_done <= i_buf_rd && cnt_q[1:0] == 2'h3;
      o_hold_poll <= i_hold && div_q == 4'h0;
      if (i_buf_rd) begin
        cnt_q <= cnt_q + 8'h01;
        stall_q <= {cnt_q[1:0], 3'h0};
      end else if (stall_q != 5'h00) begin
        stall_q <= stall_q - 5'h01;
      end
    end
  end
endmodule // tcc_line_model

// ==== verif/test_tx_channel_command_control.sv ====
// Testbench of the transmit command block with its line and DMA model.
// Assumes the block answers every bus transfer with one wait state.
`timescale 1ns/10ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin bad_count++; \
  $display("wrong value %s exp %0h got %0h", nm, e, s); end end
module test_tx_channel_command_control;
  logic i_clk, i_rstn, i_hsel, i_hwrite;
  logic [31:0] i_haddr, i_hwdata, rd, cfg, desc_adr;
  logic [1:0] i_htrans;
  logic [7:0] cap_q, flag;
  logic [5:0] sz;
  wire [31:0] o_hrdata, o_dma_addr;
  wire [7:0] bd;
  wire [5:0] o_buf_size;
  wire o_hreadyout, lclk, tslot, o_txd, o_txd_oe, bv, bfe, o_buf_rd, dd, hp, o_dma_branch, o_hold;
  int bad_count, n_checks, cap_n, k, j;
  integer seed = 32'ha8b8;
  tcc_tx_cmd u_tcc_tx_cmd (.i_clk(i_clk), .i_rstn(i_rstn), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2),
    .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout), .o_hresp(), .i_link_clk(lclk), .i_tslot(tslot),
    .o_txd(o_txd), .o_txd_oe(o_txd_oe), .i_buf_valid(bv), .i_buf_data(bd), .i_buf_end(bfe),
    .o_buf_rd(o_buf_rd), .i_desc_done(dd), .i_hold_poll(hp), .o_dma_branch(o_dma_branch),
    .o_dma_flush(), .o_dma_addr(o_dma_addr), .o_buf_size(o_buf_size), .o_hold(o_hold));
  tcc_line_model u_tcc_line_model (.i_clk(i_clk), .i_rstn(i_rstn), .i_buf_rd(o_buf_rd),
    .i_hold(o_hold), .o_link_clk(lclk), .o_tslot(tslot), .o_buf_valid(bv),
    .o_buf_data(bd), .o_buf_end(bfe), .o_desc_done(dd), .o_hold_poll(hp));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // Serial bits taken mid-bit, least significant first
  always @(negedge lclk) begin
    if (o_txd_oe === 1'b1) begin
      cap_q = {o_txd, cap_q[7:1]};
      cap_n++;
    end
  end
  task automatic wrap_up();
    if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic lim(input int n);
    if (k >= n) begin
      bad_count++;
      wrap_up();
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= {24'h0, a};
    i_hwrite <= w;
    k = 0;
    do begin @(posedge i_clk); k++; end while (o_hreadyout !== 1'b1 && k < 20);
    i_htrans <= 2'h0;
    i_hwdata <= d;
    do begin @(posedge i_clk); k++; end while (o_hreadyout !== 1'b1 && k < 40);
    rd = o_hrdata;
    lim(40);
  endtask
  function automatic logic [7:0] fill_exp(input logic [31:0] c);
    if (c[2:0] == 3'h3) return c[3] ? 8'hFF : 8'h7E;
    if (c[2:0] == 3'h0) return c[4] ? c[15:8] : 8'hFF;
    return 8'h00;
  endfunction
  initial begin
    i_rstn = 1'b0;
    i_hsel = 1'b0;
    i_htrans = 2'h0;
    i_haddr = 32'h0;
    i_hwrite = 1'b0;
    i_hwdata = 32'h0;
    repeat (12) @(posedge i_clk);
    i_rstn <= 1'b1;
    @(posedge i_clk);
    `CHK("reset", 39'h0, {o_dma_addr, o_buf_size, o_hold})
    ahb(0, 8'h04, 32'h0);
    `CHK("cfg", 32'h0000_7E00, rd)
    ahb(0, 8'h20, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    desc_adr = $random(seed);
    sz = 6'($unsigned($random(seed)) % 63 + 1);
    ahb(1, 8'h08, desc_adr);
    ahb(1, 8'h00, {18'h0, sz, 8'h15});
    ahb(0, 8'h08, 32'h0);
    `CHK("desc_adr", desc_adr, rd)
    `CHK("size", sz, o_buf_size)
    for (int i = 0; i < 10; i++) begin
      flag = $random(seed);
      // Odd passes keep the loop bit set through the off command
      cfg = {16'h0, flag, 2'h0, 1'(i % 2), i >= 5, i >= 5, 3'(i % 5)};
      ahb(1, 8'h04, cfg & 32'hFFFF_FFF8);
      ahb(1, 8'h00, 32'h2);
      ahb(1, 8'h04, cfg);
      `CHK("oe", 1'b0, o_txd_oe)
      // Reinitialise between slots so the fill octet fills one whole slot
      k = 0;
      while (tslot !== 1'b1 && k < 1000) begin @(posedge i_clk); k++; end
      while (tslot !== 1'b0 && k < 1000) begin @(posedge i_clk); k++; end
      lim(1000);
      ahb(1, 8'h00, 32'h5);
      cap_n = 0;
      k = 0;
      while (cap_n < 8 && k < 2000) begin @(posedge i_clk); k++; end
      lim(2000);
      `CHK("fill", fill_exp(cfg), cap_q)
    end
    ahb(1, 8'h04, 32'h0000_7E03);
    k = 0;
    while (o_buf_rd !== 1'b1 && k < 3000) begin @(posedge i_clk); k++; end
    lim(3000);
    ahb(1, 8'h00, 32'h3);
    ahb(0, 8'h10, 32'h0);
    `CHK("abort", 2'b10, rd[2:1])
    ahb(1, 8'h00, 32'h5);
    ahb(0, 8'h10, 32'h0);
    `CHK("init", 3'b001, rd[2:0])
    desc_adr = $random(seed);
    ahb(1, 8'h08, desc_adr);
    ahb(1, 8'h00, 32'h4);
    k = 0;
    while (o_dma_branch !== 1'b1 && k < 4000) begin @(posedge i_clk); k++; end
    lim(4000);
    @(posedge i_clk);
    `CHK("branch", desc_adr, o_dma_addr)
    ahb(1, 8'h00, 32'h8);
    j = 0;
    do begin ahb(0, 8'h10, 32'h0); j++; end while (rd[14:8] < sz + 2 && j < 600);
    k = j;
    lim(600);
    `CHK("drained", 2'b11, {rd[6], rd[3]})
    wrap_up();
  end
endmodule // test_tx_channel_command_control
